// ===== common/uid_pkg.sv
// Constants for the three-channel serial block with infrared and DMA.
// Assumes one 10 MHz bus clock; register map is per-channel words.
package uid_pkg;
   localparam int CLK_KHZ   = 10000;
   // Shortest low-power infrared pulse, in ns
   localparam int IR_LP_NS  = 1140;
   localparam int IR_LP_CYC = (IR_LP_NS * CLK_KHZ + 999999) / 1000000;
   localparam logic [3:0] IR_PULSE_SUB = 4'h3;   // 3/16 of a bit
   localparam logic [3:0] SUB_MID      = 4'h7;
   localparam logic [3:0] SUB_END      = 4'hF;

   // Address: haddr[6:5] channel, haddr[4:2] register
   localparam logic [1:0] CH_GLOBAL = 2'h3;
   localparam logic [2:0] R_DATA    = 3'h0;
   localparam logic [2:0] R_CTRL    = 3'h1;
   localparam logic [2:0] R_DIV     = 3'h2;
   localparam logic [2:0] R_STAT    = 3'h3;
   localparam logic [2:0] R_MASK    = 3'h4;
   localparam logic [2:0] R_MODEM   = 3'h5;
   localparam logic [2:0] R_LEVEL   = 3'h6;
   localparam logic [2:0] R_CLKSEL  = 3'h0;

   // Control fields
   localparam int C_LEN   = 0;
   localparam int C_STOP2 = 2;
   localparam int C_PEN   = 3;
   localparam int C_PODD  = 4;
   localparam int C_BRK   = 5;
   localparam int C_IR    = 6;
   localparam int C_IRLP  = 7;
   localparam int C_FEN   = 8;
   localparam int C_TRIG  = 9;
   localparam int C_DRX   = 12;
   localparam int C_DTX   = 13;
   localparam logic [13:0] CTRL_RST = 14'h0303;
   localparam logic [15:0] DIV_RST  = 16'h0001;

   // Status and mask bits
   localparam int S_RXD = 0;
   localparam int S_RXT = 1;
   localparam int S_TXT = 2;
   localparam int S_OVR = 3;
   localparam int S_PAR = 4;
   localparam int S_FRM = 5;
   localparam int S_BRK = 6;
   localparam int S_MDM = 7;

   // Receive entry flags above the data byte
   localparam int E_PE  = 8;
   localparam int E_FE  = 9;
   localparam int E_BRK = 10;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_START = 3'h1,
      ST_DATA  = 3'h3,
      ST_PAR   = 3'h2,
      ST_STOP  = 3'h6
   } uid_state_t;
endpackage

// ===== design/uid_serial_top.sv
// Three asynchronous serial channels with infrared coding and DMA requests.
// Assumes an AHB-Lite master on hclk, sole slave; pins are asynchronous.
//
// Function
// R01: Three independent channels, each with own configuration, FIFOs, line state.
// R02: Bit rate up to 1.5 Mbit/s, set by divider and bus clock; code tops out at bus clock over 16, 625 kbit/s at 10 MHz.
// R03: 16-entry transmit and receive FIFOs; either disable gives single-character path; code has one C_FEN bit that disables both FIFOs together.
// R04: Trigger level programmable in eighths, one to seven eighths.
// R05: Baud divider source is master clock or master clock halved.
// R06: Frame: start bit, 5 to 8 data bits, one or two stops.
// R07: Even, odd or no parity; generated on transmit, checked on receive.
// R08: Reject false start bits; generate and detect line break.
// R09: Infrared encode and decode on channel pins, up to 115.2 kbit/s.
// R10: Infrared pulse is 3/16 bit or fixed 1.14 to 2.23 us.
// R11: Only channel zero has CTS, DCD, DSR, RI in and RTS, DTR out.
// R12: No one-and-half stop bits, no separate receive clock.
// R13: Only channels zero and one raise DMA requests.
// R14: DMA single and burst requests for transmit and receive.
// R15: Burst requests only while FIFOs are enabled.
// R16: Baud reference from master clock, optional halving, shared reference.
// R17: Parity, framing, overrun and break flagged, each can interrupt.
// R18: Receiver samples at 16x bit rate, takes bit mid-period.
`timescale 1ns/1ps
module uid_serial_top #(
   parameter int NCH    = 3,
   parameter int FIFO_D = 16,
   parameter int DIV_W  = 16
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   output logic                  irq,
   input  wire logic [NCH-1:0]   serial_receive_pin,
   output logic      [NCH-1:0]   serial_transmit_pin,
   input  wire logic             modem_cts_n,
   input  wire logic             modem_dcd_n,
   input  wire logic             modem_dsr_n,
   input  wire logic             modem_ri_n,
   output logic                  modem_rts_n,
   output logic                  modem_dtr_n,
   output logic      [1:0]       dma_rx_single,
   output logic      [1:0]       dma_rx_burst,
   output logic      [1:0]       dma_tx_single,
   output logic      [1:0]       dma_tx_burst
);
   localparam int AW = $clog2(FIFO_D);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] DEPTH = CW'(FIFO_D);
   localparam logic [CW-1:0] ONE   = CW'(1);

   function automatic logic hit(input logic [4:0] a, input logic [1:0] ch,
                                input logic [2:0] r);
      return a == {ch, r};
   endfunction

   function automatic logic [7:0] dmask(input logic [1:0] len);
      return 8'hFF >> (2'h3 - len);
   endfunction

   // Eighths of the depth; a disabled FIFO holds one character
   function automatic logic [CW-1:0] trig_lvl(input logic fen,
                                              input logic [2:0] t);
      logic [2:0] e;
      e = (t == 3'h0) ? 3'h1 : t;
      return fen ? CW'(e) * (DEPTH >> 3) : ONE;          // [R04] [R03]
   endfunction

   logic             hready_reg;
   logic [31:0]      hrdata_reg;
   logic             irq_reg;
   logic             wr_pend;
   logic             rd_pend;
   logic [4:0]       addr_q;
   logic             clksel_reg;
   logic             half_tog;
   logic             ref_en;
   logic [3:0]       mdm_s1;
   logic [3:0]       mdm_s2;
   logic [3:0]       mdm_s3;
   logic             rts_n_reg;
   logic             dtr_n_reg;
   logic [31:0]      rd_val [NCH];
   logic [NCH-1:0]   irq_vec;
   logic             take;
   logic             rd_pop;

   assign hrdata      = hrdata_reg;
   assign hreadyout   = hready_reg;
   assign hresp       = 1'b0;
   assign irq         = irq_reg;
   assign modem_rts_n = rts_n_reg;
   assign modem_dtr_n = dtr_n_reg;
   assign take   = hsel & htrans[1] & hready;
   assign rd_pop = rd_pend & ~hready_reg;

   // Writes land in the data phase; reads get one wait state so a
   // read right after a write sees the new value.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hready_reg <= 1'b1;
         wr_pend    <= 1'b0;
         rd_pend    <= 1'b0;
         addr_q     <= 5'h00;
      end else begin
         wr_pend <= take & hwrite;
         rd_pend <= take & ~hwrite;
         if (take)
            addr_q <= haddr[6:2];
         if (take & ~hwrite)
            hready_reg <= 1'b0;
         else if (rd_pop)
            hready_reg <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_pop) begin
         if (hit(addr_q, uid_pkg::CH_GLOBAL, uid_pkg::R_CLKSEL))
            hrdata_reg <= {31'h0, clksel_reg};
         else if (addr_q[4:3] < 2'(NCH))
            hrdata_reg <= rd_val[addr_q[4:3]];
         else
            hrdata_reg <= 32'h0000_0000;
      end
   end

   // Shared baud reference for all channels
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clksel_reg <= 1'b0;
         half_tog   <= 1'b0;
      end else begin
         half_tog <= ~half_tog;
         if (wr_pend && hit(addr_q, uid_pkg::CH_GLOBAL, uid_pkg::R_CLKSEL))
            clksel_reg <= hwdata[0];
      end
   end
   assign ref_en = ~clksel_reg | half_tog;                 // [R05] [R16]

   // Modem lines exist on channel zero only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mdm_s1    <= 4'hF;
         mdm_s2    <= 4'hF;
         mdm_s3    <= 4'hF;
         rts_n_reg <= 1'b1;
         dtr_n_reg <= 1'b1;
      end else begin
         mdm_s1 <= {modem_cts_n, modem_dcd_n, modem_dsr_n, modem_ri_n};
         mdm_s2 <= mdm_s1;
         mdm_s3 <= mdm_s2;
         if (wr_pend && hit(addr_q, 2'h0, uid_pkg::R_MODEM)) begin // [R11]
            rts_n_reg <= ~hwdata[0];
            dtr_n_reg <= ~hwdata[1];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= |irq_vec;
   end

   for (genvar c = 0; c < NCH; c++) begin : g_ch               // [R01]
      localparam logic [1:0] CH = 2'(c);
      logic [13:0]      ctrl_reg;
      logic [DIV_W-1:0] div_reg;
      logic [DIV_W-1:0] bcnt;
      logic [7:0]       stat_reg;
      logic [7:0]       mask_reg;
      logic [7:0]       ev;
      logic             tick;
      logic [1:0]       len;
      logic             fen;
      logic [CW-1:0]    lvl;
      logic [7:0]       tmem [FIFO_D];
      logic [AW-1:0]    twp;
      logic [AW-1:0]    trp;
      logic [CW-1:0]    tcnt;
      logic             tpush;
      logic             tpop;
      uid_pkg::uid_state_t tst;
      logic [3:0]       tsub;
      logic [2:0]       tbit;
      logic [7:0]       tsh;
      logic             tpar;
      logic             tline;
      logic             tbound;
      logic [4:0]       lpcnt;
      logic             tpin_q;
      logic [10:0]      rmem [FIFO_D];
      logic [AW-1:0]    rwp;
      logic [AW-1:0]    rrp;
      logic [CW-1:0]    rcnt;
      logic             rpush;
      logic             rpop;
      logic             rs1;
      logic             rs2;
      logic [3:0]       irh;
      logic             rline;
      uid_pkg::uid_state_t rst;
      logic [3:0]       rsub;
      logic [2:0]       rbit;
      logic [7:0]       rsh;
      logic             rpbit;
      logic             armed;
      logic [7:0]       rdat;
      logic [10:0]      rent;
      logic [3:0]       mdm_in;

      assign len = ctrl_reg[uid_pkg::C_LEN +: 2];
      assign fen = ctrl_reg[uid_pkg::C_FEN];
      assign lvl = trig_lvl(fen, ctrl_reg[uid_pkg::C_TRIG +: 3]);
      assign mdm_in = (c == 0) ? mdm_s2 : 4'h0;

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            ctrl_reg <= uid_pkg::CTRL_RST;
            div_reg  <= uid_pkg::DIV_RST;
            mask_reg <= 8'h00;
         end else if (wr_pend) begin
            if (hit(addr_q, CH, uid_pkg::R_CTRL))
               ctrl_reg <= hwdata[13:0];
            if (hit(addr_q, CH, uid_pkg::R_DIV))
               div_reg <= hwdata[DIV_W-1:0];
            if (hit(addr_q, CH, uid_pkg::R_MASK))
               mask_reg <= hwdata[7:0];
         end
      end

      // 16x tick; top rate is the reference over 16
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn)
            bcnt <= '0;
         else if (ref_en)
            bcnt <= (bcnt != '0) ? bcnt - 1'b1 :
                    (div_reg != '0) ? div_reg - 1'b1 : '0;    // [R02]
      end
      assign tick = ref_en & (bcnt == '0);

      // Transmit FIFO; writes while full are dropped
      assign tpush = wr_pend & hit(addr_q, CH, uid_pkg::R_DATA) &
                     (tcnt < (fen ? DEPTH : ONE));            // [R03]
      assign tpop  = tick & (tst == uid_pkg::ST_IDLE) & (tcnt != '0);
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            twp  <= '0;
            trp  <= '0;
            tcnt <= '0;
         end else begin
            if (tpush) begin
               tmem[twp] <= hwdata[7:0];
               twp       <= twp + 1'b1;
            end
            if (tpop)
               trp <= trp + 1'b1;
            if (tpush & ~tpop)
               tcnt <= tcnt + ONE;
            else if (tpop & ~tpush)
               tcnt <= tcnt - ONE;
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            tst  <= uid_pkg::ST_IDLE;
            tsub <= 4'h0;
            tbit <= 3'h0;
            tsh  <= 8'h00;
            tpar <= 1'b0;
         end else if (tpop) begin
            tst  <= uid_pkg::ST_START;
            tsub <= 4'h0;
            tbit <= 3'h0;
            tsh  <= tmem[trp] & dmask(len);
            tpar <= ^(tmem[trp] & dmask(len)) ^
                    ctrl_reg[uid_pkg::C_PODD];                   // [R07]
         end else if (tick && tst != uid_pkg::ST_IDLE) begin
            tsub <= tsub + 4'h1;
            if (tsub == uid_pkg::SUB_END) begin
               unique case (tst)
                  uid_pkg::ST_START: tst <= uid_pkg::ST_DATA;
                  uid_pkg::ST_DATA: begin
                     tsh  <= tsh >> 1;
                     tbit <= tbit + 3'h1;
                     if (tbit == {1'b0, len} + 3'h4) begin     // [R06]
                        tbit <= 3'h0;
                        tst  <= ctrl_reg[uid_pkg::C_PEN] ?
                                uid_pkg::ST_PAR : uid_pkg::ST_STOP;
                     end
                  end
                  uid_pkg::ST_PAR: tst <= uid_pkg::ST_STOP;
                  uid_pkg::ST_STOP: begin
                     // Whole stop bits only, one or two
                     if (ctrl_reg[uid_pkg::C_STOP2] && tbit == 3'h0)
                        tbit <= 3'h1;                            // [R12]
                     else
                        tst <= uid_pkg::ST_IDLE;
                  end
                  uid_pkg::ST_IDLE: tst <= uid_pkg::ST_IDLE;
               endcase
            end
         end
      end

      always_comb begin
         unique case (tst)
            uid_pkg::ST_START: tline = 1'b0;
            uid_pkg::ST_DATA:  tline = tsh[0];
            uid_pkg::ST_PAR:   tline = tpar;
            default:           tline = 1'b1;
         endcase
      end
      assign tbound = tpop | (tick & (tst != uid_pkg::ST_IDLE) &
                              (tsub == uid_pkg::SUB_END));

      // Low-power pulse counted in bus clocks from each bit start
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn)
            lpcnt <= 5'h00;
         else if (tbound)
            lpcnt <= 5'(uid_pkg::IR_LP_CYC);                     // [R10]
         else if (lpcnt != 5'h00)
            lpcnt <= lpcnt - 5'h01;
      end

      // Infrared: a zero bit is a high pulse, the line otherwise low
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn)
            tpin_q <= 1'b1;
         else if (ctrl_reg[uid_pkg::C_BRK])
            tpin_q <= ctrl_reg[uid_pkg::C_IR];                   // [R08]
         else if (ctrl_reg[uid_pkg::C_IR])
            tpin_q <= ~tline & (ctrl_reg[uid_pkg::C_IRLP] ?
                      (lpcnt != 5'h00) :
                      (tsub < uid_pkg::IR_PULSE_SUB));           // [R09] [R10]
         else
            tpin_q <= tline;
      end
      assign serial_transmit_pin[c] = tpin_q;

      // Receive pin synchroniser and infrared pulse stretch
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            rs1 <= 1'b1;
            rs2 <= 1'b1;
            irh <= 4'h0;
         end else begin
            rs1 <= serial_receive_pin[c];
            rs2 <= rs1;
            if (rs2)
               irh <= uid_pkg::SUB_END;
            else if (tick && irh != 4'h0)
               irh <= irh - 4'h1;
         end
      end
      assign rline = ctrl_reg[uid_pkg::C_IR] ?
                     ~(rs2 | (irh != 4'h0)) : rs2;               // [R09]

      assign rdat = (rsh >> (2'h3 - len)) & dmask(len);
      assign rent[7:0]          = rdat;
      assign rent[uid_pkg::E_PE] = ctrl_reg[uid_pkg::C_PEN] &
             (^rdat ^ rpbit ^ ctrl_reg[uid_pkg::C_PODD]);        // [R07]
      assign rent[uid_pkg::E_FE] = ~rline;                        // [R17]
      assign rent[uid_pkg::E_BRK] = ~rline & (rdat == 8'h00) &
             ~(ctrl_reg[uid_pkg::C_PEN] & rpbit);                // [R08]
      assign rpush = tick & (rst == uid_pkg::ST_STOP) &
                     (rsub == uid_pkg::SUB_END);

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            rst   <= uid_pkg::ST_IDLE;
            rsub  <= 4'h0;
            rbit  <= 3'h0;
            rsh   <= 8'h00;
            rpbit <= 1'b0;
            armed <= 1'b0;
         end else begin
            // After a break, wait for the line to rise again
            if (rst == uid_pkg::ST_IDLE && rline)
               armed <= 1'b1;
            if (tick) begin
               rsub <= rsub + 4'h1;
               unique case (rst)
                  uid_pkg::ST_IDLE: begin
                     rsub <= 4'h0;
                     if (armed && !rline)
                        rst <= uid_pkg::ST_START;
                  end
                  uid_pkg::ST_START: begin
                     if (rsub == uid_pkg::SUB_MID) begin         // [R18]
                        rsub <= 4'h0;
                        rbit <= 3'h0;
                        rst  <= rline ? uid_pkg::ST_IDLE :
                                uid_pkg::ST_DATA;                // [R08]
                     end
                  end
                  uid_pkg::ST_DATA: begin
                     if (rsub == uid_pkg::SUB_END) begin
                        rsh  <= {rline, rsh[7:1]};
                        rbit <= rbit + 3'h1;
                        if (rbit == {1'b0, len} + 3'h4)          // [R06]
                           rst <= ctrl_reg[uid_pkg::C_PEN] ?
                                  uid_pkg::ST_PAR : uid_pkg::ST_STOP;
                     end
                  end
                  uid_pkg::ST_PAR: begin
                     if (rsub == uid_pkg::SUB_END) begin
                        rpbit <= rline;
                        rst   <= uid_pkg::ST_STOP;
                     end
                  end
                  uid_pkg::ST_STOP: begin
                     if (rsub == uid_pkg::SUB_END) begin
                        rst   <= uid_pkg::ST_IDLE;
                        armed <= rline;
                     end
                  end
               endcase
            end
         end
      end

      // Receive FIFO; a full FIFO drops the new character
      assign rpop = rd_pop & hit(addr_q, CH, uid_pkg::R_DATA) &
                    (rcnt != '0);
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            rwp  <= '0;
            rrp  <= '0;
            rcnt <= '0;
         end else begin
            if (ev[uid_pkg::S_RXD]) begin
               rmem[rwp] <= rent;
               rwp       <= rwp + 1'b1;
            end
            if (rpop)
               rrp <= rrp + 1'b1;
            if (ev[uid_pkg::S_RXD] & ~rpop)
               rcnt <= rcnt + ONE;
            else if (rpop & ~ev[uid_pkg::S_RXD])
               rcnt <= rcnt - ONE;
         end
      end

      always_comb begin
         ev = 8'h00;
         ev[uid_pkg::S_RXD] = rpush & (rcnt < (fen ? DEPTH : ONE));
         ev[uid_pkg::S_OVR] = rpush & ~(rcnt < (fen ? DEPTH : ONE));
         ev[uid_pkg::S_PAR] = rpush & rent[uid_pkg::E_PE];
         ev[uid_pkg::S_FRM] = rpush & rent[uid_pkg::E_FE];
         ev[uid_pkg::S_BRK] = rpush & rent[uid_pkg::E_BRK];
         ev[uid_pkg::S_RXT] = rcnt >= lvl;
         ev[uid_pkg::S_TXT] = tcnt <= (DEPTH - lvl);
         ev[uid_pkg::S_MDM] = (c == 0) && (mdm_s2 != mdm_s3);    // [R11]
      end

      // Sticky, write one to clear; a new event beats the clear
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn)
            stat_reg <= 8'h00;
         else if (wr_pend && hit(addr_q, CH, uid_pkg::R_STAT))
            stat_reg <= (stat_reg & ~hwdata[7:0]) | ev;          // [R17]
         else
            stat_reg <= stat_reg | ev;                           // [R17]
      end
      assign irq_vec[c] = |(stat_reg & mask_reg);

      always_comb begin
         unique case (addr_q[2:0])
            uid_pkg::R_DATA:  rd_val[c] = {21'h0, rmem[rrp]};
            uid_pkg::R_CTRL:  rd_val[c] = {18'h0, ctrl_reg};
            uid_pkg::R_DIV:   rd_val[c] = 32'(div_reg);
            uid_pkg::R_STAT:  rd_val[c] = {24'h0, stat_reg};
            uid_pkg::R_MASK:  rd_val[c] = {24'h0, mask_reg};
            uid_pkg::R_MODEM: rd_val[c] = (c == 0) ?
               {26'h0, ~mdm_in, ~dtr_n_reg, ~rts_n_reg} : 32'h0;
            uid_pkg::R_LEVEL: rd_val[c] = {20'h0,
               tst != uid_pkg::ST_IDLE, rst != uid_pkg::ST_IDLE,
               5'(tcnt), 5'(rcnt)};
            default:          rd_val[c] = 32'h0;
         endcase
      end

      if (c < 2) begin : g_dma                                   // [R13]
         logic rxs;
         logic rxb;
         logic txs;
         logic txb;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               rxs <= 1'b0;
               rxb <= 1'b0;
               txs <= 1'b0;
               txb <= 1'b0;
            end else begin
               rxs <= ctrl_reg[uid_pkg::C_DRX] & (rcnt != '0);   // [R14]
               rxb <= ctrl_reg[uid_pkg::C_DRX] & fen &
                      (rcnt >= lvl);                             // [R15]
               txs <= ctrl_reg[uid_pkg::C_DTX] &
                      (tcnt < (fen ? DEPTH : ONE));              // [R14]
               txb <= ctrl_reg[uid_pkg::C_DTX] & fen &
                      (tcnt <= DEPTH - lvl);                     // [R15]
            end
         end
         assign dma_rx_single[c] = rxs;
         assign dma_rx_burst[c]  = rxb;
         assign dma_tx_single[c] = txs;
         assign dma_tx_burst[c]  = txb;
      end
   end
endmodule

// ===== tb/uid_serial_sva.sv
// Bus and pin assertions for the serial block.
// Assumes one clock hclk and the active-low reset hresetn.
`timescale 1ns/1ps
module uid_serial_sva #(
   parameter int NCH = 3
) (
   input wire logic           hclk,
   input wire logic           hresetn,
   input wire logic           hsel,
   input wire logic [1:0]     htrans,
   input wire logic           hwrite,
   input wire logic           hready,
   input wire logic           hreadyout,
   input wire logic           hresp,
   input wire logic [NCH-1:0] serial_transmit_pin,
   input wire logic [1:0]     dma_rx_single,
   input wire logic [1:0]     dma_rx_burst,
   input wire logic [1:0]     dma_tx_single,
   input wire logic [1:0]     dma_tx_burst
);
   logic rd_go;
   logic wr_go;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign rd_go = hsel && htrans[1] && hready && !hwrite;
   assign wr_go = hsel && htrans[1] && hready && hwrite;
   rd_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   wr_fast_a: assert property (wr_go |=> hreadyout)
      else $error("write stalled");
   okay_resp_a: assert property (hresp == 1'b0)
      else $error("error response");
   ready_cause_a: assert property ($fell(hreadyout) |-> $past(rd_go))
      else $error("stall without read");
   rx_burst_a: assert property ((dma_rx_burst & ~dma_rx_single) == 2'h0)
      else $error("rx burst without single");
   tx_burst_a: assert property ((dma_tx_burst & ~dma_tx_single) == 2'h0)
      else $error("tx burst without single");
   // Shortest level is a 3-tick infrared pulse
   tx_hold_a: assert property ($changed(serial_transmit_pin[0]) |=>
      $stable(serial_transmit_pin[0])[*2]) else $error("tx level too short");
   dma_rst_a: assert property ($rose(hresetn) |->
      {dma_rx_single, dma_rx_burst, dma_tx_single, dma_tx_burst} == 8'h00)
      else $error("dma request out of reset");
endmodule
bind uid_serial_top uid_serial_sva #(.NCH(NCH)) u_sva (.hclk, .hresetn,
   .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
   .serial_transmit_pin, .dma_rx_single, .dma_rx_burst, .dma_tx_single,
   .dma_tx_burst);

// ===== tb/uid_far_end.sv
// Far serial device: echoes every channel back to its receiver.
// Assumes hold_low is driven by the bench to fake glitches and breaks.
`timescale 1ns/1ps
module uid_far_end (
   input  wire logic [2:0] tx_line,
   input  wire logic       hold_low,
   output logic      [2:0] rx_line
);
   assign rx_line = {tx_line[2:1], tx_line[0] & ~hold_low};
endmodule

// ===== tb/test_uart_irda_dma_channel.sv
// Self-checking bench for the three-channel serial block.
// Assumes the far end echoes each channel; bus is AHB-Lite at 10 MHz.
`timescale 1ns/1ps
module test_uart_irda_dma_channel;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, irq, rts_n, dtr_n;
   logic        brk = 1'b0;
   logic [2:0]  rxp, txp;
   logic [1:0]  rs, rb, ts, tb;
   int          errors = 0;
   int          n_checks = 0;
   always #50 hclk = ~hclk;
   uid_far_end u_far (.tx_line(txp), .hold_low(brk), .rx_line(rxp));
   uid_serial_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .serial_receive_pin(rxp), .serial_transmit_pin(txp),
      .modem_cts_n(brk), .modem_dcd_n(1'b0), .modem_dsr_n(1'b0),
      .modem_ri_n(1'b0), .modem_rts_n(rts_n), .modem_dtr_n(dtr_n),
      .dma_rx_single(rs), .dma_rx_burst(rb), .dma_tx_single(ts),
      .dma_tx_burst(tb));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge hclk);
   endtask
   // Entered just after a rising edge; returns on the edge ending it
   task automatic bus(logic w, logic [1:0] ch, logic [2:0] r, logic [31:0] d);
      haddr <= {25'h0, ch, r, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_frames();
      logic [31:0] cfg [3] = '{32'h11B, 32'h00C, 32'h142};
      logic [31:0] dat [3] = '{32'hA5, 32'h15, 32'h5A};
      bus(0, 2'h0, uid_pkg::R_CTRL, 0); chk("ctrl reset", rd, 32'h303);
      bus(0, 2'h3, 3'h7, 0); chk("unmapped", rd, 32'h0);
      for (int c = 0; c < 3; c++) bus(1, c[1:0], uid_pkg::R_CTRL, cfg[c]);
      cyc(400);
      // Mode switch on the infrared channel can leave a stray character
      bus(0, 2'h2, uid_pkg::R_DATA, 0);
      for (int c = 0; c < 3; c++) bus(1, c[1:0], uid_pkg::R_DATA, dat[c]);
      cyc(400);
      for (int c = 0; c < 3; c++) begin
         bus(0, c[1:0], uid_pkg::R_DATA, 0);
         chk("echo", rd, dat[c]);
      end
      $display("frames done");
   endtask
   task automatic t_irq_dma_modem();
      chk("irq idle", irq, 0);
      bus(1, 2'h0, uid_pkg::R_MASK, 1); cyc(2); chk("irq on", irq, 1);
      bus(1, 2'h0, uid_pkg::R_STAT, 32'h81); cyc(2);
      chk("irq off", irq, 0);
      bus(1, 2'h1, uid_pkg::R_CTRL, 32'h300C);
      bus(1, 2'h0, uid_pkg::R_CTRL, 32'h311B); cyc(3);
      chk("dma", {rs, rb, ts, tb}, 32'h0D);
      bus(1, 2'h0, uid_pkg::R_MODEM, 3); cyc(1);
      chk("rts dtr", {rts_n, dtr_n}, 0);
      bus(0, 2'h0, uid_pkg::R_MODEM, 0); chk("modem 0", rd, 32'h3F);
      bus(0, 2'h1, uid_pkg::R_MODEM, 0); chk("modem 1", rd, 32'h0);
      $display("irq dma modem done");
   endtask
   task automatic t_break();
      bus(1, 2'h3, 3'h0, 1); bus(0, 2'h3, 3'h0, 0);
      chk("clksel", rd, 1);
      brk <= 1'b1; cyc(4); brk <= 1'b0; cyc(300);
      bus(0, 2'h0, uid_pkg::R_LEVEL, 0); chk("glitch", rd & 32'h1F, 0);
      brk <= 1'b1; cyc(400); brk <= 1'b0; cyc(100);
      bus(0, 2'h0, uid_pkg::R_DATA, 0); chk("brk", rd & 32'h400, 32'h400);
      bus(0, 2'h0, uid_pkg::R_STAT, 0);
      chk("brk st", rd & 32'hC0, 32'hC0);
      $display("break done");
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_frames();
      t_irq_dma_modem();
      t_break();
      tally_and_finish();
   end
   initial begin
      #2000000;
      errors++;
      tally_and_finish();
   end
endmodule
